// >>> core/dmc_config.sv
// device mode configuration register and the logic it steers
// assumes cfg port, master and sram sequencer all on ref_clk
`timescale 1ns/1ps
`include "dmc_defs.svh"
module dmc_config (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic soft_chip_reset,
  input wire logic ext_ram_present_pin_n,
  input wire logic [3:0] mst_cmd_req,
  input wire logic mst_burst_active,
  input wire logic mst_data_xfer,
  input wire logic mst_line_end,
  input wire logic latency_timer_expired,
  input wire logic gnt_n,
  input wire logic [31:0] high_addr_page,
  output logic [3:0] mst_cmd_out,
  output logic mst_release,
  output logic mst_use_dac,
  output logic ext_block_slow_cycle,
  input wire logic ext_sram_rd_valid,
  input wire logic [8:0] ext_sram_rd_data,
  output logic ext_parity_err,
  input wire logic ram_wr,
  input wire logic [3:0] ram_wr_addr,
  input wire logic [7:0] ram_wr_data,
  input wire logic ram_rd,
  input wire logic [3:0] ram_rd_addr,
  output logic [7:0] ram_rd_data,
  output logic ram_parity_err,
  input wire logic term_power_on,
  output logic term_power_ctl_out,
  output logic diff_active_negation_en,
  output logic spare_config_bit
);
  import dmc_pkg::*;

  // ----------------------------------------
  // configuration register
  // ----------------------------------------
  dmc_byte_t device_mode_config;
  dmc_rel_t rel_state;
  dmc_rel_t next_rel_state;
  wire cfg_hit = cfg_dword == `DMC_CFG_DWORD;
  wire cfg_lane_wr = cfg_wr && cfg_hit && cfg_be[`DMC_BYTE_LANE];
  wire [7:0] cfg_lane_data = cfg_wdata[7:0];

  // soft_chip_reset deliberately unused here: only bus reset clears it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      device_mode_config <= `DMC_RESET_VALUE;
    end else if (cfg_lane_wr) begin
      device_mode_config <= cfg_lane_data;
    end
  end

  wire plain_read_cmd_enable = device_mode_config[`DMC_BIT_PLAIN_RD];
  wire ext_block_parity_check_en = device_mode_config[`DMC_BIT_EXT_PAR];
  wire parity_invert_test = device_mode_config[`DMC_BIT_PAR_INV];
  wire dual_addr_enable = device_mode_config[`DMC_BIT_DAC];
  wire term_power_polarity = device_mode_config[`DMC_BIT_TERM_POL];

  // ----------------------------------------
  // ram present strap, three-stage sync
  // ----------------------------------------
  logic [2:0] ramps_sync;
  logic ext_ram_present;
  wire ramps_agree = ramps_sync[1] == ramps_sync[2];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ramps_sync <= `DMC_SYNC_CLEAR;
    end else begin
      ramps_sync <= {ramps_sync[1:0], ~ext_ram_present_pin_n};
    end
  end
  // latched only once stages two and three agree, so a glitch never shows
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_ram_present <= 1'b0;
    end else if (ramps_agree) begin
      ext_ram_present <= ramps_sync[2];
    end
  end

  // ----------------------------------------
  // config read
  // ----------------------------------------
  // a miss reads zero, so the data lines never carry stale bits
  wire cfg_rd_hit = cfg_rd && cfg_hit;
  wire [31:0] rd_word = {22'h0, ext_ram_present, 1'b0, device_mode_config};
  wire [31:0] next_cfg_rdata = cfg_rd_hit ? rd_word : `DMC_RDATA_IDLE;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cfg_rdata <= `DMC_RDATA_IDLE;
    end else begin
      cfg_rdata <= next_cfg_rdata;
    end
  end

  // ----------------------------------------
  // master command and bus release
  // ----------------------------------------
  wire is_plain_rd = mst_cmd_req == `DMC_CMD_MRD;
  wire is_line_rd = (mst_cmd_req == `DMC_CMD_MRL) || (mst_cmd_req == `DMC_CMD_MRM);
  // plain read promoted to read-line when disabled; line read is the safe superset
  wire [3:0] next_cmd = (is_plain_rd && !plain_read_cmd_enable) ? `DMC_CMD_MRL
                        : mst_cmd_req;
  wire release_cond = latency_timer_expired && gnt_n && mst_burst_active;
  wire page_nonzero = |high_addr_page;
  logic burst_is_line;
  wire next_burst_is_line = is_line_rd || (is_plain_rd && !plain_read_cmd_enable);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      burst_is_line <= 1'b0;
    end else if (!mst_burst_active) begin
      burst_is_line <= next_burst_is_line;
    end
  end

  // ----------------------------------------
  // bus release state machine
  // ----------------------------------------
  always_comb begin
    next_rel_state = rel_state;
    case (rel_state)
      DMC_REL_IDLE: begin
        if (release_cond && burst_is_line) begin
          next_rel_state = plain_read_cmd_enable ? DMC_REL_NEXT : DMC_REL_LINE;
        end
      end
      DMC_REL_NEXT: begin
        if (!mst_burst_active) begin
          next_rel_state = DMC_REL_IDLE;
        end
      end
      DMC_REL_LINE: begin
        if (!mst_burst_active) begin
          next_rel_state = DMC_REL_IDLE;
        end
      end
      default: begin
        next_rel_state = DMC_REL_IDLE;
      end
    endcase
  end

  // counts the current and the next transfer once release is armed
  logic [1:0] xfer_cnt;
  wire rel_next_done = (rel_state == DMC_REL_NEXT) && mst_data_xfer
                       && (xfer_cnt == `DMC_XFER_LAST);
  wire rel_line_done = (rel_state == DMC_REL_LINE) && mst_data_xfer && mst_line_end;
  wire [1:0] next_xfer_cnt = (rel_state == DMC_REL_NEXT) ? xfer_cnt + {1'b0, mst_data_xfer}
                             : `DMC_XFER_NONE;
  wire next_mst_release = rel_next_done || rel_line_done;
  wire next_mst_use_dac = dual_addr_enable && page_nonzero;

  // ----------------------------------------
  // master registers
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rel_state <= DMC_REL_IDLE;
    end else begin
      rel_state <= next_rel_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      xfer_cnt <= `DMC_XFER_NONE;
    end else begin
      xfer_cnt <= next_xfer_cnt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mst_release <= 1'b0;
    end else begin
      mst_release <= next_mst_release;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mst_cmd_out <= `DMC_CMD_IDLE;
    end else begin
      mst_cmd_out <= next_cmd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mst_use_dac <= 1'b0;
    end else begin
      mst_use_dac <= next_mst_use_dac;
    end
  end

  // ----------------------------------------
  // pad and sram mode outputs
  // ----------------------------------------
  wire next_slow_cycle = device_mode_config[`DMC_BIT_SLOW_CYC];
  wire next_diff_neg = device_mode_config[`DMC_BIT_DIFF_NEG];
  wire next_spare_bit = device_mode_config[`DMC_BIT_SPARE];
  // xor keeps the pin at the inactive level of either polarity when off
  wire next_term_ctl = term_power_on ^ term_power_polarity;

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_block_slow_cycle <= 1'b0;
    end else begin
      ext_block_slow_cycle <= next_slow_cycle;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      diff_active_negation_en <= 1'b0;
    end else begin
      diff_active_negation_en <= next_diff_neg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      spare_config_bit <= 1'b0;
    end else begin
      spare_config_bit <= next_spare_bit;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      term_power_ctl_out <= 1'b0;
    end else begin
      term_power_ctl_out <= next_term_ctl;
    end
  end

  // ----------------------------------------
  // external sram parity check
  // ----------------------------------------
  // an 8-bit part has no ninth bit; software must leave checking off for it
  wire ext_odd_ok = ^ext_sram_rd_data;
  wire next_ext_parity_err = ext_sram_rd_valid && ext_block_parity_check_en
                             && ext_ram_present && !ext_odd_ok;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ext_parity_err <= 1'b0;
    end else begin
      ext_parity_err <= next_ext_parity_err;
    end
  end

  // ----------------------------------------
  // internal byte store with parity
  // ----------------------------------------
  // stored parity is undefined until written once after power-up
  wire gen_par = ~(^ram_wr_data) ^ parity_invert_test;
  logic [8:0] ram_q;
  logic rd_pending;

  dmc_parity_ram u_ram (
    .ref_clk(ref_clk),
    .wr_en(ram_wr),
    .wr_addr(ram_wr_addr),
    .wr_data({gen_par, ram_wr_data}),
    .rd_addr(ram_rd_addr),
    .rd_data(ram_q)
  );

  wire [7:0] next_ram_rd_data = rd_pending ? ram_q[7:0] : ram_rd_data;
  wire next_ram_parity_err = rd_pending && !(^ram_q);

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_pending <= 1'b0;
    end else begin
      rd_pending <= ram_rd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ram_rd_data <= `DMC_BYTE_CLEAR;
    end else begin
      ram_rd_data <= next_ram_rd_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      ram_parity_err <= 1'b0;
    end else begin
      ram_parity_err <= next_ram_parity_err;
    end
  end
endmodule : dmc_config

// >>> core/dmc_defs.svh
// constants for the device mode configuration register block
// assumes a pci config port with dword address and byte enables
`ifndef DMC_DEFS_SVH
`define DMC_DEFS_SVH
`define DMC_CFG_DWORD 6'h10
`define DMC_RESET_VALUE 8'h00
`define DMC_BIT_SPARE 7
`define DMC_BIT_PLAIN_RD 6
`define DMC_BIT_SLOW_CYC 5
`define DMC_BIT_EXT_PAR 4
`define DMC_BIT_PAR_INV 3
`define DMC_BIT_DAC 2
`define DMC_BIT_TERM_POL 1
`define DMC_BIT_DIFF_NEG 0
`define DMC_BYTE_LANE 0
`define DMC_RAMPS_LANE 1
`define DMC_RAMPS_BIT 9
`define DMC_CMD_MRD 4'h6
`define DMC_CMD_MRL 4'hE
`define DMC_CMD_MRM 4'hC
`define DMC_XFER_LAST 2'h1
`define DMC_XFER_NONE 2'h0
`define DMC_CMD_IDLE 4'h0
`define DMC_RDATA_IDLE 32'h0000_0000
`define DMC_SYNC_CLEAR 3'h0
`define DMC_BYTE_CLEAR 8'h00
`endif

// >>> core/dmc_parity_ram.sv
// small byte memory with a stored parity bit per byte
// assumes writer and reader sit on ref_clk
`timescale 1ns/1ps
module dmc_parity_ram (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [3:0] wr_addr,
  input wire logic [8:0] wr_data,
  input wire logic [3:0] rd_addr,
  output logic [8:0] rd_data
);
  logic [8:0] mem [0:15];
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule : dmc_parity_ram

// >>> core/dmc_pkg.sv
// types for the device mode configuration block
// assumes dmc_defs.svh is on the include path
package dmc_pkg;
  typedef enum logic [2:0] {
    DMC_REL_IDLE = 3'b001,
    DMC_REL_NEXT = 3'b010,
    DMC_REL_LINE = 3'b100
  } dmc_rel_t;
  typedef logic [7:0] dmc_byte_t;
endpackage : dmc_pkg

// >>> sim/dmc_config_asserts.sv
// checker on the mode config register ports
// assumes binding into dmc_config, one clock, sync reset
`timescale 1ns/1ps
module dmc_config_asserts (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [5:0] cfg_dword,
  input wire logic [3:0] cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic [3:0] mst_cmd_req,
  input wire logic [3:0] mst_cmd_out,
  input wire logic mst_data_xfer,
  input wire logic mst_line_end,
  input wire logic latency_timer_expired,
  input wire logic gnt_n,
  input wire logic mst_release,
  input wire logic [31:0] high_addr_page,
  input wire logic mst_use_dac,
  input wire logic ext_sram_rd_valid,
  input wire logic [8:0] ext_sram_rd_data,
  input wire logic ext_parity_err,
  input wire logic term_power_on,
  input wire logic term_power_ctl_out,
  input wire logic spare_config_bit,
  input wire logic ext_block_slow_cycle,
  input wire logic diff_active_negation_en
);
  logic [7:0] shadow;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // mirror rebuilt from config writes, so outputs are judged against intent
  always_ff @(posedge ref_clk) begin
    if (sys_rst) shadow <= 8'h00;
    else if (cfg_wr && cfg_dword == 6'h10 && cfg_be[0]) shadow <= cfg_wdata[7:0];
  end
  sequence s_hit_rd;
    cfg_rd && cfg_dword == 6'h10;
  endsequence
  chk_copy_bits: assert property (1 |=> {spare_config_bit, ext_block_slow_cycle,
    diff_active_negation_en} == {$past(shadow[7]), $past(shadow[5]), $past(shadow[0])})
    else $error("mode copy bits differ");
  chk_cmd_map: assert property (1 |=> mst_cmd_out ==
    (($past(mst_cmd_req) == 4'h6 && !$past(shadow[6])) ? 4'hE : $past(mst_cmd_req)))
    else $error("master command wrong");
  chk_dac_gate: assert property (1 |=> mst_use_dac ==
    ($past(shadow[2]) && $past(high_addr_page) != 32'h0)) else $error("dac select wrong");
  chk_term_level: assert property (1 |=> term_power_ctl_out ==
    ($past(term_power_on) ^ $past(shadow[1]))) else $error("term power level wrong");
  chk_read_back: assert property (s_hit_rd |=> cfg_rdata[8:0] == {1'b0, $past(shadow)}
    && cfg_rdata[31:10] == 22'h0) else $error("readback wrong");
  chk_read_idle: assert property (!(cfg_rd && cfg_dword == 6'h10) |=>
    cfg_rdata == 32'h0) else $error("read data not idle");
  chk_bus_release: assert property (mst_release |-> $past(gnt_n && latency_timer_expired
    && mst_data_xfer && (shadow[6] || mst_line_end))) else $error("bus release early");
  chk_ext_parity: assert property (ext_parity_err |-> $past(ext_sram_rd_valid
    && shadow[4] && !(^ext_sram_rd_data))) else $error("ext parity flag wrong");
endmodule : dmc_config_asserts
bind dmc_config dmc_config_asserts i_chk (.ref_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_dword,
  .cfg_be, .cfg_wdata, .cfg_rdata, .mst_cmd_req, .mst_cmd_out, .mst_data_xfer, .mst_line_end,
  .latency_timer_expired, .gnt_n, .mst_release, .high_addr_page, .mst_use_dac,
  .ext_sram_rd_valid, .ext_sram_rd_data, .ext_parity_err, .term_power_on, .term_power_ctl_out,
  .spare_config_bit, .ext_block_slow_cycle, .diff_active_negation_en);

// >>> sim/dmc_config_tb.sv
// self-checking bench for the mode config register
// assumes dmc_config and the bound checker are compiled first
`timescale 1ns/1ps
module dmc_config_tb;
  logic ref_clk = 0, sys_rst = 1, cfg_wr = 0, cfg_rd = 0, soft_chip_reset = 0, gnt_n = 1;
  logic burst = 0, xfer = 0, line_end = 0, lat_exp = 0, term_on = 0, ram_wr = 0, ram_rd = 0;
  logic sr_req = 0, bad_par = 0, sr_valid, ext_err, ram_err, hit_d = 0, ram_d1 = 0, ram_d2 = 0;
  logic ev_d = 0, ramps_n = 0, rel;
  int xfer_seen = 0;
  logic [5:0] cfg_dword = 6'h10;
  logic [3:0] cfg_be = 4'h0, mst_cmd_req = 4'h0, ram_addr = 4'h0;
  logic [31:0] cfg_wdata = 0, high_addr_page = 0, cfg_rdata, rnd, exp_q[$];
  logic [7:0] ram_wdata = 0, ram_rd_data, sr_byte = 0, shadow = 0;
  logic [8:0] sr_data;
  integer seed = 32'h2a8c0bf9;
  int bad_count = 0, tests_run = 0;
  dmc_config i_dmc_config (.ref_clk, .sys_rst, .cfg_wr, .cfg_rd, .cfg_dword, .cfg_be, .cfg_wdata,
    .cfg_rdata, .soft_chip_reset, .ext_ram_present_pin_n(ramps_n), .mst_cmd_req,
    .mst_burst_active(burst), .mst_data_xfer(xfer), .mst_line_end(line_end),
    .latency_timer_expired(lat_exp), .gnt_n, .high_addr_page, .mst_cmd_out(), .mst_release(rel),
    .mst_use_dac(), .ext_block_slow_cycle(), .ext_sram_rd_valid(sr_valid),
    .ext_sram_rd_data(sr_data), .ext_parity_err(ext_err), .ram_wr, .ram_wr_addr(ram_addr),
    .ram_wr_data(ram_wdata), .ram_rd, .ram_rd_addr(ram_addr), .ram_rd_data,
    .ram_parity_err(ram_err), .term_power_on(term_on), .term_power_ctl_out(),
    .diff_active_negation_en(), .spare_config_bit());
  dmc_sram_model i_sram (.ref_clk, .rd_req(sr_req), .rd_byte(sr_byte), .bad_par,
    .rd_valid(sr_valid), .rd_data(sr_data));
  always #12.5 ref_clk = ~ref_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc
  task automatic cfg_write(input logic [5:0] dw, input logic [3:0] be, input logic [7:0] d);
    cfg_dword = dw;
    cfg_be = be;
    cfg_wdata = {24'hA5C3E1, d};
    cfg_wr = 1;
    if (dw == 6'h10 && be[0]) shadow = d;
    cyc(1);
    cfg_wr = 0;
    cyc(1);
  endtask : cfg_write
  task automatic cfg_read(input logic [5:0] dw);
    cfg_dword = dw;
    cfg_rd = 1;
    if (dw == 6'h10) exp_q.push_back({22'h0, ~ramps_n, 1'b0, shadow});
    cyc(1);
    cfg_rd = 0;
    cyc(1);
  endtask : cfg_read
  // results are matched to the oldest note the cycle they appear
  always @(posedge ref_clk) begin
    hit_d <= cfg_rd && cfg_dword == 6'h10;
    ram_d1 <= ram_rd;
    ram_d2 <= ram_d1;
    ev_d <= sr_valid;
    xfer_seen <= burst ? xfer_seen + xfer : 0;
  end
  always @(negedge ref_clk) begin
    if (hit_d) check(cfg_rdata, exp_q.pop_front(), "cfg_rdata");
    if (rel) check(xfer_seen, exp_q.pop_front(), "mst_release");
    if (ram_d2) check({ram_err, ram_rd_data}, exp_q.pop_front(), "ram_rd_data");
    if (ev_d) check(ext_err, exp_q.pop_front(), "ext_parity_err");
  end
  initial begin
    cyc(5000);
    bad_count++;
    close_out();
  end
  initial begin
    cyc(6);
    sys_rst = 0;
    cyc(4);
    cfg_read(6'h10);
    for (int i = 0; i < 24; i++) begin
      rnd = $random(seed);
      soft_chip_reset = rnd[31];
      term_on = rnd[30];
      high_addr_page = {30'h0, rnd[29:28]};
      mst_cmd_req = (i % 3 == 0) ? 4'h6 : rnd[27:24];
      cfg_write((i % 4 == 3) ? 6'h11 : 6'h10, rnd[11:8], rnd[7:0]);
      cfg_read((i % 5 == 4) ? 6'h11 : 6'h10);
    end
    $display("test random_access done");
    cfg_write(6'h10, 4'h1, 8'hFF);
    sys_rst = 1;
    shadow = 8'h00;
    ramps_n = 1;
    cyc(2);
    sys_rst = 0;
    // the strap needs four edges through its synchroniser
    cyc(4);
    cfg_read(6'h10);
    ramps_n = 0;
    $display("test mid_reset done");
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      cfg_write(6'h10, 4'h1, {4'h0, i[1], 3'h0});
      ram_addr = i[3:0];
      ram_wdata = rnd[7:0];
      ram_wr = 1;
      cyc(1);
      ram_wr = 0;
      ram_rd = 1;
      exp_q.push_back({23'h0, i[1], rnd[7:0]});
      cyc(1);
      ram_rd = 0;
      cyc(3);
    end
    $display("test ram_parity done");
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      cfg_write(6'h10, 4'h1, {3'h0, i[1], 4'h0});
      bad_par = i[0];
      sr_byte = rnd[7:0];
      sr_req = 1;
      exp_q.push_back({31'h0, i[0] & i[1]});
      cyc(1);
      sr_req = 0;
      cyc(3);
    end
    $display("test ext_parity done");
    for (int m = 0; m < 2; m++) begin
      cfg_write(6'h10, 4'h1, {1'b0, m[0], 6'h0});
      mst_cmd_req = 4'hE;
      cyc(1);
      burst = 1;
      lat_exp = 1;
      gnt_n = 1;
      // armed on an idle edge: plain-read mode frees after two, line mode at line end
      exp_q.push_back(m[0] ? 32'h2 : 32'h4);
      cyc(1);
      for (int k = 0; k < 4; k++) begin
        xfer = 1;
        line_end = (k == 3);
        cyc(1);
        xfer = 0;
        line_end = 0;
        cyc(1);
      end
      burst = 0;
      lat_exp = 0;
      cyc(3);
    end
    $display("test bus_release done");
    check(exp_q.size(), 0, "pending notes");
    close_out();
  end
endmodule : dmc_config_tb

// >>> sim/dmc_sram_model.sv
// external 9-bit command-block sram stand-in
// assumes ref_clk; answers one cycle after each request
`timescale 1ns/1ps
module dmc_sram_model (
  input wire logic ref_clk,
  input wire logic rd_req,
  input wire logic [7:0] rd_byte,
  input wire logic bad_par,
  output logic rd_valid,
  output logic [8:0] rd_data
);
  initial rd_valid = 1'b0;
  initial rd_data = 9'h0A5;
  always @(posedge ref_clk) begin
    rd_valid <= rd_req;
    // a 9-bit part, so checking stays legal; idle data flips each cycle
    rd_data <= rd_req ? {(^rd_byte) ^ !bad_par, rd_byte} : ~rd_data;
  end
endmodule : dmc_sram_model
